// file: design/pcc_defs.vh
/*
  Constants for the PCI concurrency and second-level cache control registers.
  Assumes inclusion by bare name from the design files; definitions only.
*/
`ifndef PCC_DEFS_VH
`define PCC_DEFS_VH

// ============================================================
// Configuration offsets
`define PCC_OFS_PCI_CTRL 8'h50
`define PCC_OFS_L2_CTRL 8'h52

// ============================================================
// Reset values and writable masks
`define PCC_PCI_CTRL_RESET 8'h00
`define PCC_PCI_CTRL_WMASK 8'h08
`define PCC_L2_LOW_RESET 4'h2
`define PCC_L2_STRAP_RESET 4'h0
`define PCC_L2_CTRL_WMASK 8'hFB
`define PCC_RD_IDLE 8'h00

// ============================================================
// Field positions
`define PCC_PCE_BIT 3
`define PCC_SIZE_HI 7
`define PCC_SIZE_LO 6
`define PCC_KIND_HI 5
`define PCC_KIND_LO 4
`define PCC_NAD_BIT 3
`define PCC_FMISS_BIT 1
`define PCC_L1EN_BIT 0
`define PCC_STRAP_HI 7
`define PCC_STRAP_LO 4
`define PCC_LOW_HI 3
`define PCC_LOW_LO 0

// ============================================================
// Field encodings
`define PCC_SIZE_NONE 2'h0
`define PCC_SIZE_256K 2'h1
`define PCC_SIZE_512K 2'h2
`define PCC_SIZE_RSVD 2'h3
`define PCC_KIND_TWO_BANK_PB 2'h3

`endif

// file: design/pcc_strap_sync.v
/*
  Synchroniser for the processor reset pin and the four host address strap
  pins, with a one-cycle load pulse on the rising edge of processor reset.
  Assumes the pins are asynchronous to ref_clk and straps are stable there.
*/
`timescale 1ns/10ps
`include "pcc_defs.vh"

module pcc_strap_sync (
  // Clock and reset
  input wire ref_clk,
  input wire reset,
  // Pins
  input wire processorResetPin,
  input wire [3:0] hostAddrPin,
  // Strap result
  output reg strapLoad_r,
  output reg [3:0] strapValue_r
);

  // ============================================================
  // Two-flop synchronisers, one per pin
  wire [4:0] pinIn;
  wire [4:0] pinSync;
  reg procResetDly_r;

  assign pinIn = {processorResetPin, hostAddrPin};

  genvar gi;
  generate
    for (gi = 0; gi < 5; gi = gi + 1) begin : gSync
      reg meta_r;
      reg sync_r;
      always @(posedge ref_clk) begin
        if (reset) begin
          meta_r <= 1'b0;
          sync_r <= 1'b0;
        end else begin
          meta_r <= pinIn[gi];
          sync_r <= meta_r;
        end
      end
      assign pinSync[gi] = sync_r;
    end
  endgenerate

  // ============================================================
  // Edge detect and inverted strap capture
  always @(posedge ref_clk) begin
    if (reset) begin
      procResetDly_r <= 1'b0;
      strapLoad_r <= 1'b0;
      strapValue_r <= `PCC_L2_STRAP_RESET;
    end else begin
      procResetDly_r <= pinSync[4];
      strapLoad_r <= pinSync[4] & ~procResetDly_r;
      if (pinSync[4] & ~procResetDly_r) begin
        strapValue_r <= ~pinSync[3:0];
      end
    end
  end

endmodule // pcc_strap_sync

// file: design/pcc_regs.v
/*
  PCI concurrency control and second-level cache control registers, with
  the bus hold-off, cache enable and next-address outputs they steer.
  Assumes configuration accesses, PCI master status and cache engine
  requests arrive from logic on ref_clk; strap and processor reset pins
  are asynchronous.
*/
// Contract
// - Concurrency on: processor may reach memory during peer traffic
// - Concurrency off: hold processor off during PCI master
// - Size field loads inverted address 31:30 strap
// - L2 runs only with size nonzero and L1 enabled
// - RAM kind field loads inverted address 29:28 strap
// - Kind 11 selects two-bank pipelined burst SRAM
// - 512K burst SRAM delays next-address one clock
// - Next-address disable set: output never asserted
// - Disable clear: next-address follows cache type, size
// - Cache register low nibble resets to 0010
// - L1 disabled: cache enable negated, no fills
// - Force miss makes every tag lookup miss
`timescale 1ns/10ps
`include "pcc_defs.vh"

module pcc_regs (
  // Clock and reset
  input wire ref_clk,
  input wire reset,
  // Configuration access
  input wire cfgWrite,
  input wire cfgRead,
  input wire [7:0] cfgAddr,
  input wire [7:0] cfgWrData,
  output reg [7:0] cfgRdData_r,
  output reg cfgRdValid_r,
  // Strap pins
  input wire processorResetPin,
  input wire [3:0] hostAddrPin,
  // PCI master status
  input wire pciMasterActive,
  input wire pciMasterIsCompanion,
  input wire pciTargetIsPeer,
  // Processor cycle status
  input wire cpuCacheableCycle,
  input wire cpuRead,
  input wire nextAddrRequest,
  input wire l2BurstRead,
  // Control outputs
  output reg cpuHoldOff_r,
  output reg cacheEnableOutN_r,
  output reg nextAddrOutN_r,
  output reg l2Enable_r,
  output reg l2FillAllow_r,
  output reg l2ForceMissOut_r,
  output reg l2TagInvalidate_r,
  output reg l2TwoBankPb_r,
  output reg [1:0] l2SizeKb_r,
  // Concurrency enable view
  output reg pciConcurrencyEnOut_r
);

  // ============================================================
  // Register state and next values
  reg pciConcurrencyEn_r;
  reg pciConcurrencyEn_nxt;
  reg [1:0] l2SizeSel_r;
  reg [1:0] l2SizeSel_nxt;
  reg [1:0] l2RamKind_r;
  reg [1:0] l2RamKind_nxt;
  reg nextAddrDisable_r;
  reg nextAddrDisable_nxt;
  reg l2ForceMiss_r;
  reg l2ForceMiss_nxt;
  reg l1CacheEn_r;
  reg l1CacheEn_nxt;
  reg nextAddrReqDly_r;

  // ============================================================
  // Output next values
  reg [7:0] cfgRdData_nxt;
  reg cfgRdValid_nxt;
  reg cpuHoldOff_nxt;
  reg cacheEnableOutN_nxt;
  reg nextAddrOutN_nxt;
  reg l2Enable_nxt;
  reg l2FillAllow_nxt;
  reg l2ForceMissOut_nxt;
  reg l2TagInvalidate_nxt;
  reg l2TwoBankPb_nxt;
  reg [1:0] l2SizeKb_nxt;
  reg pciConcurrencyEnOut_nxt;

  wire strapLoad;
  wire [3:0] strapValue;
  wire writePci;
  wire writeL2;
  wire [7:0] pciCtrlView;
  wire [7:0] l2CtrlView;
  wire l2Populated;
  wire l2Active;
  wire pb512;
  wire peerConcurrent;
  wire nextAddrWant;
  wire [7:0] pciResetWord;
  wire [3:0] l2LowReset;
  wire [3:0] l2StrapReset;
  wire [1:0] strapSize;
  wire [1:0] strapKind;
  wire [1:0] resetSize;
  wire [1:0] resetKind;

  // ============================================================
  // Strap capture
  pcc_strap_sync uStrap (
    .ref_clk(ref_clk),
    .reset(reset),
    .processorResetPin(processorResetPin),
    .hostAddrPin(hostAddrPin),
    .strapLoad_r(strapLoad),
    .strapValue_r(strapValue)
  );

  // ============================================================
  // Reset constants and strap fields
  assign pciResetWord = `PCC_PCI_CTRL_RESET;
  assign l2LowReset = `PCC_L2_LOW_RESET;
  assign l2StrapReset = `PCC_L2_STRAP_RESET;
  assign strapSize = strapValue[`PCC_SIZE_HI - `PCC_STRAP_LO:`PCC_SIZE_LO - `PCC_STRAP_LO];
  assign strapKind = strapValue[`PCC_KIND_HI - `PCC_STRAP_LO:`PCC_KIND_LO - `PCC_STRAP_LO];
  assign resetSize = l2StrapReset[`PCC_SIZE_HI - `PCC_STRAP_LO:`PCC_SIZE_LO - `PCC_STRAP_LO];
  assign resetKind = l2StrapReset[`PCC_KIND_HI - `PCC_STRAP_LO:`PCC_KIND_LO - `PCC_STRAP_LO];

  // ============================================================
  // Decode
  assign writePci = cfgWrite & (cfgAddr == `PCC_OFS_PCI_CTRL);
  assign writeL2 = cfgWrite & (cfgAddr == `PCC_OFS_L2_CTRL);

  // Reserved bits fixed at zero
  assign pciCtrlView = {4'h0, pciConcurrencyEn_r, 3'h0};
  assign l2CtrlView = {l2SizeSel_r, l2RamKind_r, nextAddrDisable_r, 1'h0,
    l2ForceMiss_r, l1CacheEn_r};

  // ============================================================
  // PCI control register
  always @* begin
    pciConcurrencyEn_nxt = pciConcurrencyEn_r;
    if (writePci) begin
      pciConcurrencyEn_nxt = cfgWrData[`PCC_PCE_BIT];
    end
  end

  always @(posedge ref_clk) begin
    if (reset) begin
      pciConcurrencyEn_r <= pciResetWord[`PCC_PCE_BIT];
    end else begin
      pciConcurrencyEn_r <= pciConcurrencyEn_nxt;
    end
  end

  // ============================================================
  // Cache control register
  // Strap load wins the upper nibble over a same-cycle write
  always @* begin
    l2SizeSel_nxt = l2SizeSel_r;
    l2RamKind_nxt = l2RamKind_r;
    nextAddrDisable_nxt = nextAddrDisable_r;
    l2ForceMiss_nxt = l2ForceMiss_r;
    l1CacheEn_nxt = l1CacheEn_r;
    if (strapLoad) begin
      l2SizeSel_nxt = strapSize;
      l2RamKind_nxt = strapKind;
    end else if (writeL2) begin
      l2SizeSel_nxt = cfgWrData[`PCC_SIZE_HI:`PCC_SIZE_LO];
      l2RamKind_nxt = cfgWrData[`PCC_KIND_HI:`PCC_KIND_LO];
    end
    if (writeL2) begin
      nextAddrDisable_nxt = cfgWrData[`PCC_NAD_BIT];
      l2ForceMiss_nxt = cfgWrData[`PCC_FMISS_BIT];
      l1CacheEn_nxt = cfgWrData[`PCC_L1EN_BIT];
    end
  end

  always @(posedge ref_clk) begin
    if (reset) begin
      l2SizeSel_r <= resetSize;
      l2RamKind_r <= resetKind;
      nextAddrDisable_r <= l2LowReset[`PCC_NAD_BIT];
      l2ForceMiss_r <= l2LowReset[`PCC_FMISS_BIT];
      l1CacheEn_r <= l2LowReset[`PCC_L1EN_BIT];
    end else begin
      l2SizeSel_r <= l2SizeSel_nxt;
      l2RamKind_r <= l2RamKind_nxt;
      nextAddrDisable_r <= nextAddrDisable_nxt;
      l2ForceMiss_r <= l2ForceMiss_nxt;
      l1CacheEn_r <= l1CacheEn_nxt;
    end
  end

  // ============================================================
  // Read path
  always @* begin
    cfgRdValid_nxt = cfgRead;
    cfgRdData_nxt = cfgRdData_r;
    if (cfgRead) begin
      case (cfgAddr)
        `PCC_OFS_PCI_CTRL: cfgRdData_nxt = pciCtrlView;
        `PCC_OFS_L2_CTRL: cfgRdData_nxt = l2CtrlView;
        default: cfgRdData_nxt = `PCC_RD_IDLE;
      endcase
    end
  end

  always @(posedge ref_clk) begin
    if (reset) begin
      cfgRdData_r <= `PCC_RD_IDLE;
      cfgRdValid_r <= 1'b0;
    end else begin
      cfgRdData_r <= cfgRdData_nxt;
      cfgRdValid_r <= cfgRdValid_nxt;
    end
  end

  // ============================================================
  // Cache mode decode
  assign l2Populated = (l2SizeSel_r != `PCC_SIZE_NONE);
  assign l2Active = l2Populated & l1CacheEn_r;
  assign pb512 = (l2SizeSel_r == `PCC_SIZE_512K) &
    (l2RamKind_r == `PCC_KIND_TWO_BANK_PB);

  // ============================================================
  // Bus concurrency
  assign peerConcurrent = pciConcurrencyEn_r & ~pciMasterIsCompanion &
    pciTargetIsPeer;

  always @* begin
    cpuHoldOff_nxt = pciMasterActive & ~peerConcurrent;
    pciConcurrencyEnOut_nxt = pciConcurrencyEn_r;
  end

  always @(posedge ref_clk) begin
    if (reset) begin
      cpuHoldOff_r <= 1'b0;
      pciConcurrencyEnOut_r <= 1'b0;
    end else begin
      cpuHoldOff_r <= cpuHoldOff_nxt;
      pciConcurrencyEnOut_r <= pciConcurrencyEnOut_nxt;
    end
  end

  // ============================================================
  // Cache enable, fills and tag lookups
  always @* begin
    cacheEnableOutN_nxt = ~(l1CacheEn_r & cpuCacheableCycle);
    l2Enable_nxt = l2Active;
    l2FillAllow_nxt = l2Active & ~l2ForceMiss_r;
    l2ForceMissOut_nxt = l2ForceMiss_r;
    l2TagInvalidate_nxt = l2Populated & ~l1CacheEn_r & l2ForceMiss_r & cpuRead;
    l2TwoBankPb_nxt = (l2RamKind_r == `PCC_KIND_TWO_BANK_PB);
    if (l2SizeSel_r == `PCC_SIZE_RSVD) begin
      l2SizeKb_nxt = `PCC_SIZE_NONE;
    end else begin
      l2SizeKb_nxt = l2SizeSel_r;
    end
  end

  always @(posedge ref_clk) begin
    if (reset) begin
      cacheEnableOutN_r <= 1'b1;
      l2Enable_r <= 1'b0;
      l2FillAllow_r <= 1'b0;
      l2ForceMissOut_r <= 1'b1;
      l2TagInvalidate_r <= 1'b0;
      l2TwoBankPb_r <= 1'b0;
      l2SizeKb_r <= `PCC_SIZE_NONE;
    end else begin
      cacheEnableOutN_r <= cacheEnableOutN_nxt;
      l2Enable_r <= l2Enable_nxt;
      l2FillAllow_r <= l2FillAllow_nxt;
      l2ForceMissOut_r <= l2ForceMissOut_nxt;
      l2TagInvalidate_r <= l2TagInvalidate_nxt;
      l2TwoBankPb_r <= l2TwoBankPb_nxt;
      l2SizeKb_r <= l2SizeKb_nxt;
    end
  end

  // ============================================================
  // Next-address output
  // Delayed copy avoids deselecting the active bank too early
  assign nextAddrWant = (pb512 & l2BurstRead) ? nextAddrReqDly_r : nextAddrRequest;

  always @* begin
    nextAddrOutN_nxt = ~(nextAddrWant & ~nextAddrDisable_r & l2Active);
  end

  always @(posedge ref_clk) begin
    if (reset) begin
      nextAddrReqDly_r <= 1'b0;
      nextAddrOutN_r <= 1'b1;
    end else begin
      nextAddrReqDly_r <= nextAddrRequest;
      nextAddrOutN_r <= nextAddrOutN_nxt;
    end
  end

endmodule // pcc_regs

// file: test/pcc_regs_chk.sv
/* Port checker for pcc_regs.
   Assumes a bind from the bench top file. */
`timescale 1ns/10ps
module pcc_regs_chk (
  // Clock and reset
  input wire ref_clk,
  input wire reset,
  // Inputs
  input wire cfgRead,
  input wire [7:0] cfgAddr,
  input wire pciMasterActive,
  input wire pciMasterIsCompanion,
  input wire pciTargetIsPeer,
  input wire cpuCacheableCycle,
  input wire nextAddrRequest,
  // Outputs
  input wire [7:0] cfgRdData_r,
  input wire cfgRdValid_r,
  input wire cpuHoldOff_r,
  input wire cacheEnableOutN_r,
  input wire nextAddrOutN_r,
  input wire l2Enable_r,
  input wire l2FillAllow_r,
  input wire l2ForceMissOut_r,
  input wire l2TagInvalidate_r,
  input wire pciConcurrencyEnOut_r
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (reset);
  a_hold_off: assert property (cpuHoldOff_r == ($past(pciMasterActive) &&
    !(pciConcurrencyEnOut_r && !$past(pciMasterIsCompanion) && $past(pciTargetIsPeer))))
    else $error("hold off wrong");
  a_ken_gate: assert property (!$past(cpuCacheableCycle) |-> cacheEnableOutN_r)
    else $error("cache enable without cacheable cycle");
  a_na_cause: assert property (!nextAddrOutN_r |->
    $past(nextAddrRequest) || $past(nextAddrRequest, 2)) else $error("next address uncaused");
  a_fill_gate: assert property (l2FillAllow_r |-> l2Enable_r && !l2ForceMissOut_r)
    else $error("fill while disabled");
  a_tag_inv: assert property (l2TagInvalidate_r |-> l2ForceMissOut_r && cacheEnableOutN_r)
    else $error("tag invalidate wrong");
  a_rd_valid: assert property (cfgRdValid_r == $past(cfgRead))
    else $error("read valid timing");
  a_pci_rsvd: assert property (cfgRdValid_r && $past(cfgAddr) == 8'h50 |->
    cfgRdData_r[7:4] == 4'h0 && cfgRdData_r[2:0] == 3'h0) else $error("reserved bits set");
  a_l2_rsvd: assert property (cfgRdValid_r && $past(cfgAddr) == 8'h52 |->
    !cfgRdData_r[2]) else $error("reserved bit 2 set");
endmodule // pcc_regs_chk

// file: test/pcc_far_model.sv
/* Far-side model: processor reset pin and host address straps.
   Assumes ref_clk from the bench. */
`timescale 1ns/10ps
module pcc_far_model (
  // Clock
  input wire ref_clk,
  // Pins
  output reg processorResetPin,
  output reg [3:0] hostAddrPin
);
  initial begin
    processorResetPin = 1;
    hostAddrPin = 4'hF;
  end
  // Straps held across the rising edge, then the bus moves on
  task strap(input [3:0] lv);
    begin
      processorResetPin = 0;
      hostAddrPin = lv;
      repeat (4) @(posedge ref_clk);
      #2 processorResetPin = 1;
      repeat (6) @(posedge ref_clk);
      #2 hostAddrPin = ~lv;
    end
  endtask
endmodule // pcc_far_model

// file: test/pcc_regs_tb.sv
/* Self-checking bench for pcc_regs.
   Assumes checker and far-side model compile first. */
`timescale 1ns/10ps
module pcc_regs_tb;
  reg ref_clk = 0, reset = 1, cfgWrite = 0, cfgRead = 0;
  reg [7:0] cfgAddr = 0, cfgWrData = 0, got;
  reg pciMasterActive = 0, pciMasterIsCompanion = 0, pciTargetIsPeer = 0;
  reg cpuCacheableCycle = 0, cpuRead = 0, nextAddrRequest = 0, l2BurstRead = 0;
  wire [7:0] cfgRdData_r;
  wire [3:0] hostAddrPin;
  wire [1:0] l2SizeKb_r;
  wire cfgRdValid_r, processorResetPin, cpuHoldOff_r, cacheEnableOutN_r, nextAddrOutN_r;
  wire l2Enable_r, l2FillAllow_r, l2ForceMissOut_r, l2TagInvalidate_r, l2TwoBankPb_r;
  wire pciConcurrencyEnOut_r;
  reg [23:0] rows [0:7];
  integer miscompares = 0, check_count = 0, i;
  pcc_regs dut (.*);
  pcc_far_model far (.*);
  always #12.5 ref_clk = ~ref_clk;
  // ============================================================
  // Tasks
  task tick;
    begin
      @(posedge ref_clk);
      #2;
    end
  endtask
  task chk(input [63:0] nm, input [7:0] e, input [7:0] g);
    begin
      check_count = check_count + 1;
      if (g !== e) begin
        miscompares = miscompares + 1;
        $display("BAD %0s exp %h got %h", nm, e, g);
      end
    end
  endtask
  task wr(input [7:0] a, input [7:0] d);
    begin
      cfgAddr = a;
      cfgWrData = d;
      cfgWrite = 1;
      tick;
      cfgWrite = 0;
      tick;
    end
  endtask
  task rd(input [7:0] a);
    begin
      cfgAddr = a;
      cfgRead = 1;
      tick;
      cfgRead = 0;
      chk("rdvalid", 1, cfgRdValid_r);
      got = cfgRdData_r;
      tick;
    end
  endtask
  task na(input [7:0] c, input b, input [1:0] e);
    begin
      wr(8'h52, c);
      tick;
      cpuCacheableCycle = 1;
      l2BurstRead = b;
      nextAddrRequest = 1;
      tick;
      nextAddrRequest = 0;
      chk("na1", e[1], nextAddrOutN_r);
      tick;
      chk("na2", e[0], nextAddrOutN_r);
      chk("ken", !c[0], cacheEnableOutN_r);
      cpuCacheableCycle = 0;
      l2BurstRead = 0;
    end
  endtask
  task results;
    begin
      $display("checks %0d miscompares %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
    end
  endtask
  initial begin
    #50000;
    miscompares = miscompares + 1;
    results;
  end
  // ============================================================
  // Sequence
  initial begin
    rows[0] = 24'h50FF08;
    rows[1] = 24'h500808;
    rows[2] = 24'h52FFFB;
    rows[3] = 24'h520101;
    rows[4] = 24'h521111;
    rows[5] = 24'h522121;
    rows[6] = 24'h60FF00;
    rows[7] = 24'h520000;
    repeat (4) @(posedge ref_clk);
    #2 reset = 0;
    rd(8'h50);
    chk("pci rst", 8'h00, got);
    rd(8'h52);
    chk("l2 rst", 8'h02, got);
    far.strap(4'h9);
    rd(8'h52);
    chk("strap", 8'h62, got);
    $display("reset test done");
    for (i = 0; i < 8; i = i + 1) begin
      wr(rows[i][23:16], rows[i][15:8]);
      rd(rows[i][23:16]);
      chk("readback", rows[i][7:0], got);
    end
    $display("table test done");
    wr(8'h50, 8'h08);
    pciMasterActive = 1;
    pciTargetIsPeer = 1;
    repeat (2) tick;
    chk("holdoff", 0, cpuHoldOff_r);
    pciMasterIsCompanion = 1;
    repeat (2) tick;
    chk("holdoff", 1, cpuHoldOff_r);
    pciMasterIsCompanion = 0;
    wr(8'h50, 8'h00);
    tick;
    chk("holdoff", 1, cpuHoldOff_r);
    chk("pceout", 0, pciConcurrencyEnOut_r);
    pciMasterActive = 0;
    $display("concurrency test done");
    na(8'hB1, 1, 2'b10);
    chk("size", 2, l2SizeKb_r);
    chk("twobank", 1, l2TwoBankPb_r);
    chk("l2en", 1, l2Enable_r);
    na(8'h71, 1, 2'b01);
    chk("fill", 1, l2FillAllow_r);
    na(8'h79, 0, 2'b11);
    na(8'h30, 0, 2'b11);
    chk("l2en", 0, l2Enable_r);
    wr(8'h52, 8'h42);
    cpuRead = 1;
    repeat (2) tick;
    chk("taginv", 1, l2TagInvalidate_r);
    chk("fill", 0, l2FillAllow_r);
    chk("fmiss", 1, l2ForceMissOut_r);
    cpuRead = 0;
    $display("cache test done");
    results;
  end
endmodule // pcc_regs_tb
bind pcc_regs pcc_regs_chk chk (.*);
